/* rtl/core_sfr_pkg.sv */
// Package with offsets, field positions and reset values of the bank 0 register map.
package core_sfr_pkg;
    // --------------------
    // Register offsets within a bank.
    // --------------------
    localparam logic [6:0] OFS_INDIRECT = 7'h00;
    localparam logic [6:0] OFS_TIMER0 = 7'h01;
    localparam logic [6:0] OFS_PCLO = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_PTA = 7'h05;
    localparam logic [6:0] OFS_PTB = 7'h06;
    localparam logic [6:0] OFS_PTC = 7'h07;
    localparam logic [6:0] OFS_PCHOLD = 7'h0a;
    localparam logic [6:0] OFS_INTCTL = 7'h0b;
    localparam logic [6:0] OFS_PIRQ = 7'h0c;
    localparam logic [6:0] OFS_T1L = 7'h0e;
    localparam logic [6:0] OFS_T1H = 7'h0f;
    localparam logic [6:0] OFS_T1CTL = 7'h10;
    localparam logic [6:0] OFS_T2CNT = 7'h11;
    localparam logic [6:0] OFS_T2CTL = 7'h12;
    localparam logic [6:0] OFS_SPBUF = 7'h13;
    localparam logic [6:0] OFS_SPCTL = 7'h14;
    localparam logic [6:0] OFS_CCL = 7'h15;
    localparam logic [6:0] OFS_CCH = 7'h16;
    localparam logic [6:0] OFS_CCCTL = 7'h17;
    localparam logic [6:0] OFS_CONV = 7'h1e;
    localparam logic [6:0] OFS_ADCTL = 7'h1f;
    localparam logic [6:0] OFS_SPSTAT = 7'h14;
    // --------------------
    // Status field positions and masks of implemented bits.
    // --------------------
    localparam int STAT_BANK_HI = 6;
    localparam int STAT_BANK_LO = 5;
    localparam logic [7:0] MASK_PTA = 8'h3f;
    localparam logic [7:0] MASK_PCHOLD = 8'h1f;
    localparam logic [7:0] MASK_PIRQ = 8'h4f;
    localparam logic [7:0] MASK_T1CTL = 8'h3f;
    localparam logic [7:0] MASK_T2CTL = 8'h7f;
    localparam logic [7:0] MASK_CCCTL = 8'h3f;
    localparam logic [7:0] MASK_ADCTL = 8'hfd;
    localparam logic [7:0] MASK_SPSTAT = 8'h3f;
    // --------------------
    // Power-on values and bits kept on other resets (1 = kept).
    // --------------------
    localparam logic [7:0] POR_STATUS = 8'h18;
    localparam logic [7:0] KEEP_STATUS = 8'h1f;
    localparam logic [7:0] POR_INTCTL = 8'h00;
    localparam logic [7:0] KEEP_INTCTL = 8'h01;
    localparam logic [7:0] POR_ZERO = 8'h00;
    localparam logic [7:0] KEEP_ALL = 8'hff;
    localparam logic [7:0] KEEP_NONE = 8'h00;
    localparam logic [7:0] KEEP_PTA = 8'h10;
endpackage : core_sfr_pkg

/* rtl/sfr_cell.sv */
// One eight-bit register cell with masked write and two reset flavours.
`timescale 1ns/100ps
`default_nettype none
module sfr_cell #(
    parameter logic [7:0] MASK = 8'hff,
    parameter logic [7:0] POR_VAL = 8'h00,
    parameter logic [7:0] KEEP = 8'h00
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic power_up_in,
    input wire logic other_reset_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] value_out
);
    logic [7:0] val_ff; // Stored contents.
    logic [7:0] nxt_val; // Next contents.
    // Next value: reset flavours first, then a write; absent bits stay zero.
    always_comb begin
        nxt_val = val_ff;
        if (power_up_in) begin
            nxt_val = POR_VAL & MASK;
        end else if (other_reset_in) begin
            nxt_val = ((val_ff & KEEP) | (POR_VAL & ~KEEP)) & MASK;
        end else if (wr_in) begin
            nxt_val = wdata_in & MASK;
        end
    end
    // Register the contents; asynchronous reset loads the power-on value.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            val_ff <= POR_VAL & MASK;
        end else if (clk_en_in) begin
            val_ff <= nxt_val;
        end
    end
    assign value_out = val_ff;
endmodule // sfr_cell
`default_nettype wire

/* rtl/core_sfr_bank0_map.sv */
// Bank 0 special function register map with mirrored core registers.
//
// Summary of operation
// (R1) Indirect location accesses memory at pointer.
// (R2) Unimplemented locations and bits read zero.
// (R3) Core registers decode identically in both banks.
// (R4) No direct access to upper counter.
// (R5) Holding register loads counter bits twelve-eight.
// (R6) Pin and watchdog resets are non-power-up.
// (R7) Software keeps reserved bank bits clear.
// (R8) Serial status top two bits read zero.
// (R9) Registers stored as cells in data space.
// (R10) Bank bits choose bank zero or one.
// (R11) Power-up loads table value, others keep; here other resets keep only each cell's KEEP bits and clear the counter.
`timescale 1ns/100ps
`default_nettype none
module core_sfr_bank0_map (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic brown_out_reset_in,
    input wire logic external_reset_pin_in,
    input wire logic watchdog_reset_in,
    input wire logic [6:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] ram_rdata_in,
    input wire logic [7:0] periph_rdata_in,
    input wire logic pc_upper_load_in,
    input wire logic [7:0] pc_low_in,
    input wire logic pc_low_load_in,
    input wire logic [7:0] status_hw_in,
    input wire logic [7:0] status_hw_mask_in,
    input wire logic [7:0] intctl_hw_set_in,
    input wire logic [7:0] pirq_hw_set_in,
    input wire logic [7:0] port_a_pins_in,
    input wire logic [7:0] port_b_pins_in,
    input wire logic [7:0] port_c_pins_in,
    input wire logic [7:0] adc_in,
    input wire logic [7:0] spstat_in,
    output logic [7:0] rdata_out,
    output logic rd_valid_out,
    output logic [8:0] ram_addr_out,
    output logic ram_rd_out,
    output logic ram_wr_out,
    output logic [7:0] ram_wdata_out,
    output logic [7:0] pc_low_out,
    output logic [4:0] pc_upper_out,
    output logic [7:0] status_out,
    output logic [7:0] pointer_out,
    output logic [7:0] intctl_out,
    output logic [7:0] pirq_out,
    output logic [7:0] port_a_latch_out,
    output logic [7:0] port_b_latch_out,
    output logic [7:0] port_c_latch_out,
    output logic bank_out,
    output logic [6:0] periph_wr_addr_out,
    output logic periph_wr_out,
    output logic [7:0] periph_wdata_out
);
    import core_sfr_pkg::*;
    // --------------------
    // Reset classification.
    // --------------------
    logic power_up; // Brown-out reset behaves like power-on.
    logic other_reset; // Pin and watchdog resets keep many bits.
    assign power_up = brown_out_reset_in; // R11
    assign other_reset = !brown_out_reset_in && (external_reset_pin_in || watchdog_reset_in); // R6
    // --------------------
    // Address decode; core registers ignore the bank bit.
    // --------------------
    logic [6:0] ofs; // Offset inside the bank.
    logic bank1; // Access falls in bank 1 image.
    logic is_ind; // Indirect window selected.
    logic [6:0] eff_ofs; // Offset after indirect redirection.
    logic eff_bank1; // Bank after indirect redirection.
    logic [7:0] status_v; // Status register contents.
    logic [7:0] pointer_v; // Indirect pointer contents.
    assign ofs = addr_in;
    assign bank1 = status_v[STAT_BANK_LO]; // R10
    assign is_ind = (ofs == OFS_INDIRECT); // R1
    assign eff_ofs = is_ind ? pointer_v[6:0] : ofs; // R1
    assign eff_bank1 = is_ind ? pointer_v[7] : bank1; // R1
    // Core registers are mirrored: decode independent of bank.
    function automatic logic is_core(input logic [6:0] o);
        is_core = (o == OFS_PCLO) || (o == OFS_STATUS) || (o == OFS_POINTER) ||
                  (o == OFS_PCHOLD) || (o == OFS_INTCTL); // R3
    endfunction
    logic hit_b0; // Access reaches a bank 0 register.
    logic indirect_self; // Pointer aims back at the window itself.
    assign indirect_self = is_ind && (pointer_v[6:0] == OFS_INDIRECT);
    assign hit_b0 = is_core(eff_ofs) || !eff_bank1; // R3
    logic wr_eff; // Write not blocked by self-reference.
    assign wr_eff = wr_in && !indirect_self; // R1
    logic wr_lo, wr_stat, wr_ptr, wr_hold, wr_int, wr_pirq, wr_pa, wr_pb, wr_pc;
    assign wr_lo = wr_eff && eff_ofs == OFS_PCLO;
    assign wr_stat = wr_eff && eff_ofs == OFS_STATUS;
    assign wr_ptr = wr_eff && eff_ofs == OFS_POINTER;
    assign wr_hold = wr_eff && eff_ofs == OFS_PCHOLD;
    assign wr_int = wr_eff && eff_ofs == OFS_INTCTL;
    assign wr_pirq = wr_eff && !eff_bank1 && eff_ofs == OFS_PIRQ;
    assign wr_pa = wr_eff && !eff_bank1 && eff_ofs == OFS_PTA;
    assign wr_pb = wr_eff && !eff_bank1 && eff_ofs == OFS_PTB;
    assign wr_pc = wr_eff && !eff_bank1 && eff_ofs == OFS_PTC;
    // --------------------
    // Register cells held as flip-flops in the data space.
    // --------------------
    logic [7:0] hold_v, int_v, pirq_v, pa_v, pb_v, pc_v; // Cell contents.
    logic [7:0] stat_wdata; // Status write merged with hardware flags.
    logic stat_we; // Status cell update.
    logic [7:0] int_wdata, pirq_wdata; // Flag merges: hardware set beats clear.
    logic int_we, pirq_we; // Flag cell update.
    // Status: software writes the bank bits and flags; hardware owns masked bits.
    always_comb begin
        stat_wdata = wr_stat ? wdata_in : status_v;
        stat_wdata = (stat_wdata & ~status_hw_mask_in) | (status_hw_in & status_hw_mask_in);
        stat_we = wr_stat || (status_hw_mask_in != 8'h00);
        int_wdata = (wr_int ? wdata_in : int_v) | intctl_hw_set_in;
        int_we = wr_int || (intctl_hw_set_in != 8'h00);
        pirq_wdata = (wr_pirq ? wdata_in : pirq_v) | pirq_hw_set_in;
        pirq_we = wr_pirq || (pirq_hw_set_in != 8'h00);
    end
    sfr_cell #(.MASK(KEEP_ALL), .POR_VAL(POR_STATUS), .KEEP(KEEP_STATUS)) u_status ( // R9
        .ref_clk_in, .resetn_in, .clk_en_in,
        .power_up_in(power_up), .other_reset_in(other_reset), .wr_in(stat_we),
        .wdata_in(stat_wdata), .value_out(status_v));
    sfr_cell #(.MASK(KEEP_ALL), .POR_VAL(POR_ZERO), .KEEP(KEEP_ALL)) u_pointer (
        .ref_clk_in, .resetn_in, .clk_en_in,
        .power_up_in(power_up), .other_reset_in(other_reset), .wr_in(wr_ptr),
        .wdata_in, .value_out(pointer_v));
    sfr_cell #(.MASK(MASK_PCHOLD), .POR_VAL(POR_ZERO), .KEEP(KEEP_NONE)) u_hold ( // R5
        .ref_clk_in, .resetn_in, .clk_en_in,
        .power_up_in(power_up), .other_reset_in(other_reset), .wr_in(wr_hold),
        .wdata_in, .value_out(hold_v));
    sfr_cell #(.MASK(KEEP_ALL), .POR_VAL(POR_INTCTL), .KEEP(KEEP_INTCTL)) u_intctl (
        .ref_clk_in, .resetn_in, .clk_en_in,
        .power_up_in(power_up), .other_reset_in(other_reset), .wr_in(int_we),
        .wdata_in(int_wdata), .value_out(int_v));
    sfr_cell #(.MASK(MASK_PIRQ), .POR_VAL(POR_ZERO), .KEEP(KEEP_NONE)) u_pirq (
        .ref_clk_in, .resetn_in, .clk_en_in,
        .power_up_in(power_up), .other_reset_in(other_reset), .wr_in(pirq_we),
        .wdata_in(pirq_wdata), .value_out(pirq_v));
    sfr_cell #(.MASK(MASK_PTA), .POR_VAL(POR_ZERO), .KEEP(KEEP_PTA)) u_pta (
        .ref_clk_in, .resetn_in, .clk_en_in,
        .power_up_in(power_up), .other_reset_in(other_reset), .wr_in(wr_pa),
        .wdata_in, .value_out(pa_v));
    sfr_cell #(.MASK(KEEP_ALL), .POR_VAL(POR_ZERO), .KEEP(KEEP_ALL)) u_ptb (
        .ref_clk_in, .resetn_in, .clk_en_in,
        .power_up_in(power_up), .other_reset_in(other_reset), .wr_in(wr_pb),
        .wdata_in, .value_out(pb_v));
    sfr_cell #(.MASK(KEEP_ALL), .POR_VAL(POR_ZERO), .KEEP(KEEP_ALL)) u_ptc (
        .ref_clk_in, .resetn_in, .clk_en_in,
        .power_up_in(power_up), .other_reset_in(other_reset), .wr_in(wr_pc),
        .wdata_in, .value_out(pc_v));
    // --------------------
    // Program counter: low byte writable, upper part only via holding.
    // --------------------
    logic [7:0] lo_ff, nxt_lo; // Counter low byte.
    logic [4:0] pcu_ff, nxt_pcu; // Counter bits twelve to eight.
    // Counter update: a low-byte write also pulls the holding value up.
    always_comb begin
        nxt_lo = lo_ff;
        nxt_pcu = pcu_ff;
        if (power_up || other_reset) begin
            nxt_lo = 8'h00;
            nxt_pcu = 5'h00;
        end else if (wr_lo) begin
            nxt_lo = wdata_in;
            nxt_pcu = hold_v[4:0]; // R5
        end else begin
            if (pc_low_load_in) begin
                nxt_lo = pc_low_in;
            end
            if (pc_upper_load_in) begin
                nxt_pcu = hold_v[4:0]; // R5 R4
            end
        end
    end
    // Register the counter state.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lo_ff <= 8'h00;
            pcu_ff <= 5'h00;
        end else if (clk_en_in) begin
            lo_ff <= nxt_lo;
            pcu_ff <= nxt_pcu;
        end
    end
    // --------------------
    // Read multiplexer; unmapped offsets and absent bits give zero.
    // --------------------
    logic [7:0] rmux; // Selected read value.
    logic ram_sel; // Access falls on general purpose memory.
    logic periph_sel; // Access falls on a peripheral register.
    always_comb begin
        rmux = 8'h00; // R2
        ram_sel = 1'b0;
        periph_sel = 1'b0;
        if (indirect_self) begin
            rmux = 8'h00; // R1
        end else if (eff_ofs >= 7'h20) begin
            ram_sel = 1'b1;
            rmux = ram_rdata_in;
        end else if (hit_b0) begin
            case (eff_ofs)
                OFS_PCLO: rmux = lo_ff;
                OFS_STATUS: rmux = status_v;
                OFS_POINTER: rmux = pointer_v;
                OFS_PTA: rmux = port_a_pins_in & MASK_PTA;
                OFS_PTB: rmux = port_b_pins_in;
                OFS_PTC: rmux = port_c_pins_in;
                OFS_PCHOLD: rmux = hold_v & MASK_PCHOLD; // R4 R2
                OFS_INTCTL: rmux = int_v;
                OFS_PIRQ: rmux = pirq_v & MASK_PIRQ;
                OFS_CONV: rmux = adc_in;
                OFS_TIMER0, OFS_T1L, OFS_T1H, OFS_T2CNT, OFS_SPBUF, OFS_SPCTL,
                OFS_CCL, OFS_CCH: begin
                    periph_sel = 1'b1;
                    rmux = periph_rdata_in;
                end
                OFS_T1CTL: begin
                    periph_sel = 1'b1;
                    rmux = periph_rdata_in & MASK_T1CTL;
                end
                OFS_T2CTL: begin
                    periph_sel = 1'b1;
                    rmux = periph_rdata_in & MASK_T2CTL;
                end
                OFS_CCCTL: begin
                    periph_sel = 1'b1;
                    rmux = periph_rdata_in & MASK_CCCTL;
                end
                OFS_ADCTL: begin
                    periph_sel = 1'b1;
                    rmux = periph_rdata_in & MASK_ADCTL;
                end
                default: rmux = 8'h00; // R2
            endcase
        end else if (eff_ofs == OFS_SPSTAT) begin
            rmux = spstat_in & MASK_SPSTAT; // R8
        end else begin
            periph_sel = 1'b1;
            rmux = periph_rdata_in;
        end
    end
    // --------------------
    // Output stage; every output comes from a flip-flop.
    // --------------------
    logic [7:0] rdata_ff;
    logic rdv_ff, ramrd_ff, ramwr_ff, pwr_ff;
    logic [8:0] raddr_ff;
    logic [7:0] wd_ff;
    logic [6:0] paddr_ff;
    logic [7:0] stat_o_ff, ptr_o_ff, int_o_ff, pirq_o_ff, pa_o_ff, pb_o_ff, pc_o_ff;
    // Register bus answers, memory strobes and register images.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_ff <= 8'h00;
            rdv_ff <= 1'b0;
            ramrd_ff <= 1'b0;
            ramwr_ff <= 1'b0;
            pwr_ff <= 1'b0;
            raddr_ff <= 9'h000;
            wd_ff <= 8'h00;
            paddr_ff <= 7'h00;
            stat_o_ff <= 8'h00;
            ptr_o_ff <= 8'h00;
            int_o_ff <= 8'h00;
            pirq_o_ff <= 8'h00;
            pa_o_ff <= 8'h00;
            pb_o_ff <= 8'h00;
            pc_o_ff <= 8'h00;
        end else if (clk_en_in) begin
            rdata_ff <= rd_in ? rmux : 8'h00;
            rdv_ff <= rd_in;
            ramrd_ff <= rd_in && ram_sel;
            ramwr_ff <= wr_eff && ram_sel;
            pwr_ff <= wr_eff && periph_sel;
            raddr_ff <= {1'b0, eff_bank1, eff_ofs};
            wd_ff <= wdata_in;
            paddr_ff <= eff_ofs;
            stat_o_ff <= status_v;
            ptr_o_ff <= pointer_v;
            int_o_ff <= int_v;
            pirq_o_ff <= pirq_v;
            pa_o_ff <= pa_v;
            pb_o_ff <= pb_v;
            pc_o_ff <= pc_v;
        end
    end
    assign rdata_out = rdata_ff;
    assign rd_valid_out = rdv_ff;
    assign ram_addr_out = raddr_ff;
    assign ram_rd_out = ramrd_ff;
    assign ram_wr_out = ramwr_ff;
    assign ram_wdata_out = wd_ff;
    assign pc_low_out = lo_ff;
    assign pc_upper_out = pcu_ff;
    assign status_out = stat_o_ff;
    assign pointer_out = ptr_o_ff;
    assign intctl_out = int_o_ff;
    assign pirq_out = pirq_o_ff;
    assign port_a_latch_out = pa_o_ff;
    assign port_b_latch_out = pb_o_ff;
    assign port_c_latch_out = pc_o_ff;
    assign bank_out = stat_o_ff[STAT_BANK_LO];
    assign periph_wr_addr_out = paddr_ff;
    assign periph_wr_out = pwr_ff;
    assign periph_wdata_out = wd_ff;
endmodule // core_sfr_bank0_map
`default_nettype wire

/* sim/core_sfr_bank0_map_monitor.sv */
// Checker that watches the bank 0 register map at its ports.
`timescale 1ns/100ps
`default_nettype none
module core_sfr_bank0_map_monitor
    import core_sfr_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic brown_out_reset_in,
    input wire logic external_reset_pin_in,
    input wire logic watchdog_reset_in,
    input wire logic [6:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic pc_upper_load_in,
    input wire logic pc_low_load_in,
    input wire logic [7:0] status_hw_mask_in,
    input wire logic [7:0] rdata_out,
    input wire logic rd_valid_out,
    input wire logic ram_wr_out,
    input wire logic [7:0] ram_wdata_out,
    input wire logic [4:0] pc_upper_out,
    input wire logic [7:0] status_out,
    input wire logic bank_out
);
    // Every event that may legally move the upper counter bits, except a low-byte write through the indirect window.
    logic pc_cause;
    assign pc_cause = pc_upper_load_in || pc_low_load_in || (wr_in && addr_in == OFS_PCLO)
        || brown_out_reset_in || external_reset_pin_in || watchdog_reset_in;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    property p_rd_valid; clk_en_in && rd_in |=> rd_valid_out; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read gave no valid");
    property p_unimpl; clk_en_in && rd_in && (addr_in inside {7'h08, 7'h09, 7'h0d})
        |=> rdata_out == 8'h00; endproperty
    a_unimpl: assert property (p_unimpl) else $error("empty offset read nonzero");
    property p_hold_bits; clk_en_in && rd_in && addr_in == OFS_PCHOLD |=> rdata_out[7:5] == 3'h0;
    endproperty
    a_hold_bits: assert property (p_hold_bits) else $error("holding top bits nonzero");
    property p_spstat; clk_en_in && rd_in && addr_in == OFS_SPSTAT && bank_out && $past(bank_out)
        && $past(bank_out, 2) |=> rdata_out[7:6] == 2'h0; endproperty
    a_spstat: assert property (p_spstat) else $error("serial status top bits nonzero");
    property p_pc_upper; $changed(pc_upper_out) |-> $past(pc_cause) || $past(pc_cause, 2);
    endproperty
    a_pc_upper: assert property (p_pc_upper) else $error("upper counter moved alone");
    property p_bank; bank_out == status_out[STAT_BANK_LO]; endproperty
    a_bank: assert property (p_bank) else $error("bank differs from status");
    property p_por; brown_out_reset_in && clk_en_in && status_hw_mask_in == 8'h00 ##1 clk_en_in
        && status_hw_mask_in == 8'h00 && !wr_in |=> status_out == POR_STATUS; endproperty
    a_por: assert property (p_por) else $error("status power-up value wrong");
    property p_other; (external_reset_pin_in || watchdog_reset_in) && !brown_out_reset_in
        && clk_en_in && status_hw_mask_in == 8'h00 ##1 clk_en_in
        |=> status_out[7:5] == 3'h0 && status_out[2:0] == $past(status_out[2:0]); endproperty
    a_other: assert property (p_other) else $error("status other-reset value wrong");
    property p_ram_wdata; ram_wr_out && $past(clk_en_in) |-> ram_wdata_out == $past(wdata_in);
    endproperty
    a_ram_wdata: assert property (p_ram_wdata) else $error("memory write data wrong");
endmodule // core_sfr_bank0_map_monitor
bind core_sfr_bank0_map core_sfr_bank0_map_monitor u_monitor (.*);
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the bank 0 register map.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import core_sfr_pkg::*;
    // --------------------
    // Ports of the block.
    // --------------------
    logic ref_clk_in, resetn_in, clk_en_in, brown_out_reset_in, external_reset_pin_in;
    logic watchdog_reset_in, rd_in, wr_in, pc_upper_load_in, pc_low_load_in;
    logic rd_valid_out, ram_rd_out, ram_wr_out, bank_out, periph_wr_out;
    logic [6:0] addr_in, periph_wr_addr_out;
    logic [7:0] wdata_in, ram_rdata_in, periph_rdata_in, pc_low_in, status_hw_in;
    logic [7:0] status_hw_mask_in, intctl_hw_set_in, pirq_hw_set_in, port_a_pins_in;
    logic [7:0] port_b_pins_in, port_c_pins_in, adc_in, spstat_in, rdata_out;
    logic [7:0] ram_wdata_out, pc_low_out, status_out, pointer_out, intctl_out, pirq_out;
    logic [7:0] port_a_latch_out, port_b_latch_out, port_c_latch_out, periph_wdata_out;
    logic [8:0] ram_addr_out;
    logic [4:0] pc_upper_out;
    // Counters, memory strobes seen in the last access, and the model tables.
    int fails, checks;
    logic seen_rd, seen_wr;
    logic [8:0] seen_addr;
    logic [6:0] per_ofs [12] = '{OFS_TIMER0, OFS_T1L, OFS_T1H, OFS_T1CTL, OFS_T2CNT,
        OFS_T2CTL, OFS_SPBUF, OFS_SPCTL, OFS_CCL, OFS_CCH, OFS_CCCTL, OFS_ADCTL};
    logic [7:0] per_mask [12] = '{3: MASK_T1CTL, 5: MASK_T2CTL, 10: MASK_CCCTL,
        11: MASK_ADCTL, default: 8'hff};
    logic [6:0] core_ofs [6] = '{OFS_STATUS, OFS_PCLO, OFS_POINTER, OFS_PCHOLD, OFS_INTCTL,
        OFS_PIRQ};
    core_sfr_bank0_map u_dut (.*);
    // Clock at 25 MHz.
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    // Compares one value and counts the result.
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One read or write, launched at a falling edge, then one idle cycle.
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
                       input logic [7:0] e);
        wr_in = w;
        rd_in = !w;
        addr_in = a;
        wdata_in = d;
        @(negedge ref_clk_in);
        if (!w) check("rdata", rdata_out, e);
        if (!w) check("rd_valid", rd_valid_out, 1'b1);
        seen_rd = ram_rd_out;
        seen_wr = ram_wr_out;
        seen_addr = ram_addr_out;
        wr_in = 1'b0;
        rd_in = 1'b0;
        @(negedge ref_clk_in);
    endtask
    // Prints the verdict and stops.
    task automatic final_report();
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected length of the run.
    initial begin
        #(40 * 3000);
        fails++;
        final_report();
    end
    // Main sequence.
    initial begin
        {brown_out_reset_in, external_reset_pin_in, watchdog_reset_in, rd_in, wr_in} = '0;
        {pc_upper_load_in, pc_low_load_in, addr_in, wdata_in, ram_rdata_in} = '0;
        {periph_rdata_in, pc_low_in, status_hw_in, status_hw_mask_in, intctl_hw_set_in} = '0;
        {pirq_hw_set_in, port_a_pins_in, port_b_pins_in, port_c_pins_in, adc_in} = '0;
        spstat_in = 8'h00;
        clk_en_in = 1'b1;
        resetn_in = 1'b0;
        void'($urandom(32'h0c9368f0));
        repeat (10) @(negedge ref_clk_in);
        resetn_in = 1'b1;
        @(negedge ref_clk_in);
        for (int i = 0; i < 6; i++) acc(0, core_ofs[i], 0, (i == 0) ? POR_STATUS : 8'h00);
        for (int i = 0; i < 12; i++) begin
            periph_rdata_in = 8'($urandom);
            acc(0, per_ofs[i], 0, periph_rdata_in & per_mask[i]);
        end
        {adc_in, port_a_pins_in, port_b_pins_in, port_c_pins_in} = $urandom;
        acc(0, OFS_CONV, 0, adc_in);
        acc(0, OFS_PTA, 0, port_a_pins_in & MASK_PTA);
        acc(0, OFS_PTB, 0, port_b_pins_in);
        acc(0, OFS_PTC, 0, port_c_pins_in);
        for (int o = 0; o < 32; o++) begin
            if (o inside {8, 9, 13} || (o >= 24 && o <= 29)) begin
                acc(1, 7'(o), 8'($urandom), 0);
                acc(0, 7'(o), 0, 8'h00);
            end
        end
        // Indirect window: write, read, pointer bit 7, and the self-pointing refusal.
        acc(1, OFS_POINTER, 8'h21, 0);
        acc(1, OFS_INDIRECT, 8'h5c, 0);
        check("ram_wr", seen_wr, 1'b1);
        check("ram_addr", seen_addr, 9'h021);
        acc(1, OFS_POINTER, 8'ha5, 0);
        ram_rdata_in = 8'($urandom);
        acc(0, OFS_INDIRECT, 0, ram_rdata_in);
        check("ram_rd", seen_rd, 1'b1);
        check("ram_addr", seen_addr, 9'h0a5);
        acc(1, OFS_POINTER, 8'h80, 0);
        acc(1, OFS_INDIRECT, 8'h11, 0);
        check("ram_wr", seen_wr, 1'b0);
        acc(0, OFS_INDIRECT, 0, 8'h00);
        // Bank switch and mirrored core registers; reserved bank bits kept clear.
        acc(1, OFS_PCHOLD, 8'hff, 0);
        acc(1, OFS_STATUS, 8'h20, 0);
        check("bank", bank_out, 1'b1);
        acc(0, OFS_PCHOLD, 0, MASK_PCHOLD);
        acc(1, OFS_POINTER, 8'h3c, 0);
        check("pointer", pointer_out, 8'h3c);
        spstat_in = 8'($urandom);
        acc(0, OFS_SPSTAT, 0, spstat_in & MASK_SPSTAT);
        acc(1, OFS_STATUS, 8'h00, 0);
        check("bank", bank_out, 1'b0);
        acc(0, OFS_POINTER, 0, 8'h3c);
        // Upper counter only through the holding register.
        acc(1, OFS_PCHOLD, 8'h0a, 0);
        check("pc_upper", pc_upper_out, 5'h00);
        pc_upper_load_in = 1'b1;
        @(negedge ref_clk_in);
        pc_upper_load_in = 1'b0;
        @(negedge ref_clk_in);
        check("pc_upper", pc_upper_out, 5'h0a);
        acc(1, OFS_PCHOLD, 8'h15, 0);
        acc(1, OFS_PCLO, 8'h34, 0);
        check("pc_upper", pc_upper_out, 5'h15);
        check("pc_low", pc_low_out, 8'h34);
        pc_low_in = 8'($urandom);
        pc_low_load_in = 1'b1;
        @(negedge ref_clk_in);
        pc_low_load_in = 1'b0;
        acc(0, OFS_PCLO, 0, pc_low_in);
        // Watchdog, pin and power-up resets; power-up runs last.
        for (int k = 0; k < 3; k++) begin
            acc(1, OFS_INTCTL, 8'hff, 0);
            acc(1, OFS_POINTER, 8'h5a, 0);
            acc(1, OFS_PIRQ, 8'hff, 0);
            acc(0, OFS_PIRQ, 0, MASK_PIRQ);
            acc(1, OFS_PCHOLD, 8'h1f, 0);
            {brown_out_reset_in, external_reset_pin_in, watchdog_reset_in} = 3'b001 << k;
            @(negedge ref_clk_in);
            {brown_out_reset_in, external_reset_pin_in, watchdog_reset_in} = 3'b000;
            @(negedge ref_clk_in);
            acc(0, OFS_INTCTL, 0, (k < 2) ? KEEP_INTCTL : POR_INTCTL);
            acc(0, OFS_POINTER, 0, (k < 2) ? 8'h5a : 8'h00);
            acc(0, OFS_PIRQ, 0, 8'h00);
            acc(0, OFS_PCHOLD, 0, 8'h00);
            acc(0, OFS_PCLO, 0, 8'h00);
        end
        acc(0, OFS_STATUS, 0, POR_STATUS);
        // Hardware flag inputs land in status, interrupt control and request flags.
        {status_hw_in, status_hw_mask_in, intctl_hw_set_in, pirq_hw_set_in} = 32'h07070201;
        @(negedge ref_clk_in);
        {status_hw_in, status_hw_mask_in, intctl_hw_set_in, pirq_hw_set_in} = 32'h0;
        acc(0, OFS_STATUS, 0, 8'h1f);
        acc(0, OFS_INTCTL, 0, 8'h02);
        acc(0, OFS_PIRQ, 0, 8'h01);
        // A frozen clock enable drops the write.
        clk_en_in = 1'b0;
        acc(1, OFS_PCHOLD, 8'h07, 0);
        clk_en_in = 1'b1;
        acc(0, OFS_PCHOLD, 0, 8'h00);
        final_report();
    end
endmodule // testbench
`default_nettype wire
